// File: rtl/rstp_pkg.sv
/*
 * Constants for the reset source tracker and power-up timer.
 * Assumes a single 100 MHz clock and an 8-bit software register port.
 */
package rstp_pkg;
    // Clock and internal RC tick timing.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int RC_TICK_NS     = 32000;
    localparam int RC_TICK_CYCLES = (RC_TICK_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int POWERUP_TICKS  = 2048;
    localparam int POWERUP_WIDTH  = 11;

    // Register offsets.
    localparam logic [3:0] ADDR_RESET_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STACK_STAT = 4'h1;
    localparam logic [3:0] ADDR_CONTROL    = 4'h2;

    // Field positions in the reset control register.
    localparam int BIT_IRQ_PRIO    = 7;
    localparam int BIT_MISMATCH    = 5;
    localparam int BIT_RST_INSTR   = 4;
    localparam int BIT_WDT_TIMEOUT = 3;
    localparam int BIT_POWERDOWN   = 2;
    localparam int BIT_POR         = 1;
    localparam int BIT_BROWNOUT    = 0;

    // Field positions in the stack status and control registers.
    localparam int BIT_STK_FULL = 7;
    localparam int BIT_STK_UNF  = 6;
    localparam int BIT_STK_RST_EN = 0;
    localparam int BIT_IRQ_HIGH = 1;
    localparam int BIT_IRQ_LOW  = 2;

    // Reset values and write masks.
    localparam logic [7:0] RCTRL_POR_VALUE = 8'h3C;
    localparam logic [7:0] RCTRL_WR_MASK   = 8'hB3;
    localparam logic [7:0] STACK_POR_VALUE = 8'h00;
    localparam logic [7:0] STACK_MASK      = 8'hC0;
    localparam logic [7:0] CONTROL_RESET   = 8'h01;
    localparam logic [7:0] CONTROL_MASK    = 8'h07;

    // Power mode codes.
    localparam logic [1:0] MODE_FULL  = 2'h0;
    localparam logic [1:0] MODE_RUN   = 2'h1;
    localparam logic [1:0] MODE_IDLE  = 2'h2;
    localparam logic [1:0] MODE_SLEEP = 2'h3;

    // Program counter values.
    localparam int          PC_WIDTH     = 21;
    localparam logic [20:0] PC_RESET     = 21'h000000;
    localparam logic [20:0] VEC_HIGH     = 21'h000008;
    localparam logic [20:0] VEC_LOW      = 21'h000018;
    localparam logic [20:0] PC_WAKE_STEP = 21'h000002;

    // Configuration words under watch.
    localparam int CFG_WIDTH = 8;
    localparam int CFG_COUNT = 4;
endpackage

// File: rtl/rstp_top.sv
/*
 * Reset source tracker: combines reset sources, runs the power-up timer,
 * keeps the reset status and stack flags, and picks the restart address.
 * Assumes the CPU core drives its event strobes on ref_clk and that the
 * master clear, brown-out and regulator pins are asynchronous.
 */
// Notes on behaviour
// - Brown-out and power-on clear brownout flag.
// - Regulator off: no brown-out reset, flag stays clear.
// - Config mismatch against shadow triggers reset.
// - Only mismatch reset or a software write clears mismatch flag.
// - Every hard reset reloads configuration words.
// - Power-up timer: 11-bit, 2048 RC ticks, holds reset.
// - Delay about 66 ms, follows RC rate.
// - Timer starts after power-on pulse ends.
// - Master clear released late: run at once.
// - Power-on: flags preset, restart at zero.
// - Brown-out: preset flags, keep power-on flag.
// - Master clear, full power: flags unchanged.
// - Master clear, run mode: set timeout flag.
// - Master clear, idle/sleep: timeout set, powerdown clear.
// - Stack full with enable: reset, flag set.
// - Underflow sets flag, restart zero, any enable.
// - Watchdog while running: reset, clear timeout flag.
// - Watchdog in sleep: wake at PC+2.
// - Interrupt wake: PC+2, clear powerdown flag.
// - Enabled interrupt wake jumps to its vector.
// - Watchdog wake is no reset.
// - Reset instruction clears its flag, restarts zero.
// - Low six bits are event flags.
`timescale 1ns/10ps
module rstp_top
    import rstp_pkg::*;
#(
    parameter int NUM_CFG     = rstp_pkg::CFG_COUNT,
    parameter int TICK_CYCLES = rstp_pkg::RC_TICK_CYCLES,
    parameter int POWERUP_COUNT = rstp_pkg::POWERUP_TICKS
)
(
    // Clock and power-on reset.
    input  wire logic                               ref_clk,
    input  wire logic                               sys_rst,
    // Asynchronous pins.
    input  wire logic                               master_clear_pin_n,
    input  wire logic                               brownout_low,
    input  wire logic                               regulator_enable,
    // Configuration words and their complementary shadows.
    input  wire logic [NUM_CFG*rstp_pkg::CFG_WIDTH-1:0] cfg_value,
    input  wire logic [NUM_CFG*rstp_pkg::CFG_WIDTH-1:0] cfg_shadow,
    // Core events.
    input  wire logic [1:0]                         power_mode,
    input  wire logic [rstp_pkg::PC_WIDTH-1:0]      cur_pc,
    input  wire logic                               reset_instr,
    input  wire logic                               stack_full_evt,
    input  wire logic                               stack_underflow_evt,
    input  wire logic                               wdt_timeout,
    input  wire logic                               irq_wake,
    input  wire logic                               clrwdt_exec,
    input  wire logic                               sleep_exec,
    // Register port.
    input  wire logic [3:0]                         reg_addr,
    input  wire logic [7:0]                         reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [7:0]                         reg_rdata,
    // Reset and restart results.
    output logic                                    cpu_reset,
    output logic                                    cfg_reload,
    output logic      [rstp_pkg::PC_WIDTH-1:0]      restart_pc,
    output logic                                    restart_valid
);
    import rstp_pkg::*;

    localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    logic [2:0]            pin_async;
    logic [2:0]            sync1_reg;
    logic [2:0]            sync2_reg;
    logic                  mclear_low;
    logic                  mclear_low_d_reg;
    logic                  brownout_active;
    logic                  brownout_active_d_reg;
    logic                  reg_en;
    logic [NUM_CFG-1:0]    cfg_miss;
    logic                  mismatch;
    logic [7:0]            rctrl_reg;
    logic [7:0]            stack_reg;
    logic [7:0]            control_reg;
    logic                  powerup_busy_reg;
    logic [POWERUP_WIDTH-1:0] powerup_cnt_reg;
    logic [TICK_W-1:0]     div_cnt_reg;
    logic                  cpu_reset_reg;
    logic                  cpu_reset_next;
    logic                  cfg_reload_reg;
    logic [PC_WIDTH-1:0]   restart_pc_reg;
    logic                  restart_valid_reg;
    logic [7:0]            rdata_reg;
    logic                  run;
    logic                  idle_mode;
    logic                  stk_rst_en;
    logic                  brownout_evt;
    logic                  mismatch_evt;
    logic                  mclear_evt;
    logic                  wdt_rst_evt;
    logic                  wdt_wake_evt;
    logic                  irq_wake_evt;
    logic                  stk_full_evt;
    logic                  stk_unf_evt;
    logic                  rst_instr_evt;
    logic                  evt_rst;

    // Pins pass two flip-flops; only the second stage is read.
    assign pin_async = {regulator_enable, brownout_low, master_clear_pin_n};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end
                else
                begin
                    sync1_reg[gi] <= pin_async[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
        // Each word must equal the inverse of its shadow.
        for (gi = 0; gi < NUM_CFG; gi++)
        begin : g_cfg
            assign cfg_miss[gi] =
                cfg_value[gi*CFG_WIDTH +: CFG_WIDTH] !=
                ~cfg_shadow[gi*CFG_WIDTH +: CFG_WIDTH];
        end
    endgenerate

    assign mclear_low      = ~sync2_reg[0];
    assign reg_en          = sync2_reg[2];
    assign brownout_active = sync2_reg[1] & reg_en;
    assign mismatch        = |cfg_miss;
    assign run             = ~cpu_reset_reg;
    assign stk_rst_en      = control_reg[BIT_STK_RST_EN];
    assign idle_mode  = (power_mode == MODE_IDLE)
                        || (power_mode == MODE_SLEEP);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mclear_low_d_reg      <= 1'b1;
            brownout_active_d_reg <= 1'b0;
        end
        else
        begin
            mclear_low_d_reg      <= mclear_low;
            brownout_active_d_reg <= brownout_active;
        end
    end

    // Core events count only while the core runs.
    assign brownout_evt = brownout_active & ~brownout_active_d_reg;
    assign mismatch_evt = mismatch & run;
    assign mclear_evt   = mclear_low & ~mclear_low_d_reg & run;
    assign wdt_rst_evt  = wdt_timeout & run & ~idle_mode;
    assign wdt_wake_evt = wdt_timeout & run & idle_mode;
    assign irq_wake_evt = irq_wake & run & idle_mode;
    assign stk_full_evt  = stack_full_evt & run & stk_rst_en;
    assign stk_unf_evt   = stack_underflow_evt & run;
    assign rst_instr_evt = reset_instr & run;
    assign evt_rst       = mismatch_evt | wdt_rst_evt | stk_full_evt
                           | (stk_unf_evt & stk_rst_en) | rst_instr_evt;

    // Power-up timer. A brown-out restarts it from zero, and it only
    // counts once the power-on pulse and the brown-out have both ended.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || brownout_active)
        begin
            powerup_busy_reg <= 1'b1;
            powerup_cnt_reg  <= '0;
            div_cnt_reg      <= '0;
        end
        else if (powerup_busy_reg)
        begin
            if (div_cnt_reg == TICK_W'(TICK_CYCLES - 1))
            begin
                div_cnt_reg <= '0;
                if (powerup_cnt_reg
                    == POWERUP_WIDTH'(POWERUP_COUNT - 1))
                    powerup_busy_reg <= 1'b0;
                else
                    powerup_cnt_reg <= powerup_cnt_reg + 1'b1;
            end
            else
                div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // Level sources hold the reset; one-shot events stretch it a cycle.
    assign cpu_reset_next = mclear_low | brownout_active | powerup_busy_reg
                            | mismatch | evt_rst;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cpu_reset_reg  <= 1'b1;
            cfg_reload_reg <= 1'b1;
        end
        else
        begin
            cpu_reset_reg  <= cpu_reset_next;
            cfg_reload_reg <= cpu_reset_next & ~cpu_reset_reg;
        end
    end

    // Flag register. Hardware events come after the software write, so
    // an event in the same cycle as a write always wins.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rctrl_reg <= RCTRL_POR_VALUE;
            stack_reg <= STACK_POR_VALUE;
        end
        else
        begin
            if (reg_wr && reg_addr == ADDR_RESET_CTRL)
                rctrl_reg <= (rctrl_reg & ~RCTRL_WR_MASK)
                             | (reg_wdata & RCTRL_WR_MASK);
            if (reg_wr && reg_addr == ADDR_STACK_STAT)
                stack_reg <= reg_wdata & STACK_MASK;
            if (clrwdt_exec && run)
            begin
                rctrl_reg[BIT_WDT_TIMEOUT] <= 1'b1;
                rctrl_reg[BIT_POWERDOWN]   <= 1'b1;
            end
            if (sleep_exec && run)
            begin
                rctrl_reg[BIT_WDT_TIMEOUT] <= 1'b1;
                rctrl_reg[BIT_POWERDOWN]   <= 1'b0;
            end
            if (brownout_evt)
            begin
                rctrl_reg[BIT_MISMATCH]    <= 1'b1;
                rctrl_reg[BIT_RST_INSTR]   <= 1'b1;
                rctrl_reg[BIT_WDT_TIMEOUT] <= 1'b1;
                rctrl_reg[BIT_POWERDOWN]   <= 1'b1;
                rctrl_reg[BIT_BROWNOUT]    <= 1'b0;
            end
            if (!reg_en)
                rctrl_reg[BIT_BROWNOUT] <= 1'b0;
            if (mismatch_evt)
                rctrl_reg[BIT_MISMATCH] <= 1'b0;
            // Full-power master clear leaves every flag alone.
            if (mclear_evt && power_mode != MODE_FULL)
            begin
                rctrl_reg[BIT_WDT_TIMEOUT] <= 1'b1;
                if (idle_mode)
                    rctrl_reg[BIT_POWERDOWN] <= 1'b0;
            end
            if (wdt_timeout && run)
            begin
                rctrl_reg[BIT_WDT_TIMEOUT] <= 1'b0;
                if (idle_mode)
                    rctrl_reg[BIT_POWERDOWN] <= 1'b0;
            end
            if (irq_wake_evt)
                rctrl_reg[BIT_POWERDOWN] <= 1'b0;
            if (stk_full_evt)
                stack_reg[BIT_STK_FULL] <= 1'b1;
            if (stk_unf_evt)
                stack_reg[BIT_STK_UNF] <= 1'b1;
            if (rst_instr_evt)
                rctrl_reg[BIT_RST_INSTR] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            control_reg <= CONTROL_RESET;
        else if (reg_wr && reg_addr == ADDR_CONTROL)
            control_reg <= reg_wdata & CONTROL_MASK;
    end

    // Restart address. Later branches take precedence.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            restart_pc_reg    <= PC_RESET;
            restart_valid_reg <= 1'b0;
        end
        else
        begin
            restart_valid_reg <= 1'b0;
            if (cpu_reset_reg && !cpu_reset_next)
            begin
                restart_pc_reg    <= PC_RESET;
                restart_valid_reg <= 1'b1;
            end
            if (stk_unf_evt && !stk_rst_en)
            begin
                restart_pc_reg    <= PC_RESET;
                restart_valid_reg <= 1'b1;
            end
            if (irq_wake_evt)
            begin
                restart_valid_reg <= 1'b1;
                if (control_reg[BIT_IRQ_HIGH])
                    restart_pc_reg <= VEC_HIGH;
                else if (control_reg[BIT_IRQ_LOW])
                    restart_pc_reg <= VEC_LOW;
                else
                    restart_pc_reg <= cur_pc + PC_WAKE_STEP;
            end
            if (wdt_wake_evt)
            begin
                restart_pc_reg    <= cur_pc + PC_WAKE_STEP;
                restart_valid_reg <= 1'b1;
            end
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            rdata_reg <= 8'h00;
        else if (!reg_rd)
            rdata_reg <= 8'h00;
        else if (reg_addr == ADDR_RESET_CTRL)
            rdata_reg <= rctrl_reg;
        else if (reg_addr == ADDR_STACK_STAT)
            rdata_reg <= stack_reg;
        else if (reg_addr == ADDR_CONTROL)
            rdata_reg <= control_reg;
        else
            rdata_reg <= 8'h00;
    end

    assign reg_rdata     = rdata_reg;
    assign cpu_reset     = cpu_reset_reg;
    assign cfg_reload    = cfg_reload_reg;
    assign restart_pc    = restart_pc_reg;
    assign restart_valid = restart_valid_reg;

    sequence s_reset_entry;
        cpu_reset_reg && cfg_reload_reg;
    endsequence

    sequence s_restart_at(logic [PC_WIDTH-1:0] pc);
        restart_valid_reg && restart_pc_reg == pc;
    endsequence

    property p_por_flags;
        @(posedge ref_clk) sys_rst |=> rctrl_reg == RCTRL_POR_VALUE
            && stack_reg == STACK_POR_VALUE && cpu_reset_reg;
    endproperty
    a_por_flags: assert property (p_por_flags)
        else $error("power-on flags wrong");

    property p_brownout_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        brownout_evt |=> !rctrl_reg[BIT_BROWNOUT]
            && rctrl_reg[BIT_RST_INSTR] && cpu_reset_reg;
    endproperty
    a_brownout_clear: assert property (p_brownout_clear)
        else $error("brown-out flags wrong");

    property p_noreg_brownout;
        @(posedge ref_clk) disable iff (sys_rst)
        !reg_en |=> !rctrl_reg[BIT_BROWNOUT];
    endproperty
    a_noreg_brownout: assert property (p_noreg_brownout)
        else $error("brown-out flag set with regulator off");

    property p_mismatch_reset;
        @(posedge ref_clk) disable iff (sys_rst)
        mismatch_evt |=> s_reset_entry ##0 !rctrl_reg[BIT_MISMATCH];
    endproperty
    a_mismatch_reset: assert property (p_mismatch_reset)
        else $error("mismatch reset missing");

    property p_powerup_end;
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(powerup_busy_reg) |->
            $past(powerup_cnt_reg) == POWERUP_WIDTH'(POWERUP_COUNT - 1);
    endproperty
    a_powerup_end: assert property (p_powerup_end)
        else $error("power-up timer ended at wrong count");

    property p_mclear_release;
        @(posedge ref_clk) disable iff (sys_rst)
        ($rose(sync2_reg[0]) && !powerup_busy_reg && !brownout_active
            && !mismatch) |=> !cpu_reset_reg ##0 restart_valid_reg;
    endproperty
    a_mclear_release: assert property (p_mclear_release)
        else $error("late master clear release did not run");

    property p_wdt_wake;
        @(posedge ref_clk) disable iff (sys_rst)
        wdt_wake_evt |=> s_restart_at($past(cur_pc) + PC_WAKE_STEP)
            ##0 !rctrl_reg[BIT_WDT_TIMEOUT] && !rctrl_reg[BIT_POWERDOWN]
            && !cpu_reset_reg;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake)
        else $error("watchdog wake wrong");

    property p_irq_vec;
        @(posedge ref_clk) disable iff (sys_rst)
        irq_wake_evt && control_reg[BIT_IRQ_HIGH] && !wdt_timeout
            |=> s_restart_at(VEC_HIGH) ##0 !rctrl_reg[BIT_POWERDOWN];
    endproperty
    a_irq_vec: assert property (p_irq_vec)
        else $error("interrupt vector wrong");

    property p_mclear_sleep;
        @(posedge ref_clk) disable iff (sys_rst)
        mclear_evt && idle_mode && !wdt_timeout
            |=> rctrl_reg[BIT_WDT_TIMEOUT] && !rctrl_reg[BIT_POWERDOWN]
            ##1 cpu_reset_reg;
    endproperty
    a_mclear_sleep: assert property (p_mclear_sleep)
        else $error("master clear in sleep flags wrong");

    property p_rst_instr;
        @(posedge ref_clk) disable iff (sys_rst)
        rst_instr_evt |=> s_reset_entry ##0 !rctrl_reg[BIT_RST_INSTR];
    endproperty
    a_rst_instr: assert property (p_rst_instr)
        else $error("reset instruction handling wrong");

    property p_unf_err;
        @(posedge ref_clk) disable iff (sys_rst)
        stk_unf_evt && !stk_rst_en && !wdt_wake_evt && !irq_wake_evt
            |=> s_restart_at(PC_RESET) ##0 stack_reg[BIT_STK_UNF];
    endproperty
    a_unf_err: assert property (p_unf_err)
        else $error("underflow error handling wrong");
endmodule

// File: verification/rstp_master_clear_pin_model.sv
/*
 * Behavioural model of the external master clear source.
 * Assumes the bench commands it from the ref_clk domain and that the
 * pin carries an external pull-up resistor.
 */
`timescale 1ns/10ps
module rstp_mclear_model
(
    // Command from the bench.
    input  wire logic hold_low,
    // Pin towards the tracker.
    output logic      master_clear_pin_n
);
    // A released pin returns to the pull-up level at once, so the device
    // may start executing as soon as the pin is seen high.
    assign master_clear_pin_n = hold_low ? 1'b0 : 1'b1;
endmodule

// File: verification/testbench.sv
/*
 * Self-checking bench for the reset source tracker.
 * Assumes rstp_top with short timer parameters and a pulled-up pin.
 */
`timescale 1ns/10ps
module testbench;
    import rstp_pkg::*;
    localparam int CW = CFG_COUNT * CFG_WIDTH;
    logic          ref_clk, sys_rst, hold, pin_n, bo_low, reg_en;
    logic [CW-1:0] cfg_v, cfg_s;
    logic [1:0]    mode;
    logic [20:0]   pc, rpc;
    logic [6:0]    ev;
    logic [3:0]    addr;
    logic [7:0]    wd, rdata;
    logic          wr, rd, cpu_rst, reload, rvalid;
    int            fail_count, check_count, n, i;
    logic [7:0]    ens [3] = '{8'h01, 8'h03, 8'h05};
    logic [20:0]   vecs [3] = '{21'h000102, VEC_HIGH, VEC_LOW};
    logic [1:0]    mds [3] = '{MODE_FULL, MODE_RUN, MODE_SLEEP};
    logic [7:0]    mex [3] = '{8'h37, 8'h3F, 8'h3B};

    rstp_mclear_model u_mclear (.hold_low(hold),
                                .master_clear_pin_n(pin_n));
    rstp_top #(.NUM_CFG(CFG_COUNT), .TICK_CYCLES(4),
               .POWERUP_COUNT(8)) u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .master_clear_pin_n(pin_n),
        .brownout_low(bo_low), .regulator_enable(reg_en),
        .cfg_value(cfg_v), .cfg_shadow(cfg_s), .power_mode(mode),
        .cur_pc(pc), .reset_instr(ev[0]), .stack_full_evt(ev[1]),
        .stack_underflow_evt(ev[2]), .wdt_timeout(ev[3]),
        .irq_wake(ev[4]), .clrwdt_exec(ev[5]), .sleep_exec(ev[6]),
        .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .cpu_reset(cpu_rst), .cfg_reload(reload),
        .restart_pc(rpc), .restart_valid(rvalid));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic bad(input logic [20:0] g, input logic [20:0] e);
        fail_count++;
        $display("mismatch at %0t got %h exp %h", $time, g, e);
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) bad({13'h0, g}, {13'h0, e});
    endtask
    task automatic chk_pc(input logic [20:0] g, input logic [20:0] e);
        check_count++;
        if (g !== e) bad(g, e);
    endtask
    task automatic chk_bit(input logic g, input logic e);
        check_count++;
        if (g !== e) bad({20'h0, g}, {20'h0, e});
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a; wd <= d; wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a; rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk_byte(rdata, e);
    endtask
    task automatic pulse(input int k);
        @(posedge ref_clk);
        ev[k] <= 1'b1;
        @(posedge ref_clk);
        ev <= '0;
    endtask
    // Counts cycles until the restart strobe and checks its address.
    task automatic wait_run(input logic [20:0] e);
        n = 0;
        #1;
        while (rvalid !== 1'b1 && n < 400)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        if (n >= 400)
        begin
            bad(21'h0, 21'h1);
            give_verdict();
        end
        chk_pc(rpc, e);
    endtask
    task automatic done(input string s);
        $display("test %s ended, mismatches %0d", s, fail_count);
    endtask

    task automatic t_power_on();
        repeat (50) @(posedge ref_clk);
        chk_bit(cpu_rst, 1'b1);
        rd_chk(ADDR_RESET_CTRL, 8'h3C);
        rd_chk(ADDR_STACK_STAT, 8'h00);
        rd_chk(ADDR_CONTROL, 8'h01);
        rd_chk(4'hF, 8'h00);
        hold <= 1'b0;
        wait_run(PC_RESET);
        chk_bit(n <= 4, 1'b1);
        wr_reg(ADDR_RESET_CTRL, 8'h33);
        rd_chk(ADDR_RESET_CTRL, 8'h3F);
        done("power_on");
    endtask

    task automatic t_soft_wdt();
        pulse(0);
        #1 chk_bit(reload, 1'b1);
        wait_run(PC_RESET);
        rd_chk(ADDR_RESET_CTRL, 8'h2F);
        wr_reg(ADDR_RESET_CTRL, 8'h33);
        pulse(3);
        wait_run(PC_RESET);
        rd_chk(ADDR_RESET_CTRL, 8'h37);
        for (i = 0; i < 3; i++)
        begin
            mode <= mds[i];
            hold <= 1'b1;
            repeat (6) @(posedge ref_clk);
            chk_bit(cpu_rst, 1'b1);
            hold <= 1'b0;
            wait_run(PC_RESET);
            rd_chk(ADDR_RESET_CTRL, mex[i]);
        end
        done("soft_wdt_master_clear_pin");
    endtask

    task automatic t_wake();
        mode <= MODE_SLEEP;
        pc <= 21'h000100;
        pulse(3);
        wait_run(21'h000102);
        chk_bit(cpu_rst, 1'b0);
        rd_chk(ADDR_RESET_CTRL, 8'h33);
        mode <= MODE_IDLE;
        for (i = 0; i < 3; i++)
        begin
            wr_reg(ADDR_CONTROL, ens[i]);
            pulse(5);
            pulse(4);
            wait_run(vecs[i]);
            rd_chk(ADDR_RESET_CTRL, 8'h3B);
        end
        mode <= MODE_FULL;
        done("wake");
    endtask

    task automatic t_stack_cfg();
        wr_reg(ADDR_CONTROL, 8'h00);
        pulse(2);
        wait_run(PC_RESET);
        rd_chk(ADDR_STACK_STAT, 8'h40);
        wr_reg(ADDR_CONTROL, 8'h01);
        pulse(1);
        wait_run(PC_RESET);
        chk_bit(n > 0, 1'b1);
        rd_chk(ADDR_STACK_STAT, 8'hC0);
        rd_chk(ADDR_RESET_CTRL, 8'h3B);
        @(posedge ref_clk);
        cfg_s <= cfg_v;
        repeat (5) @(posedge ref_clk);
        chk_bit(cpu_rst, 1'b1);
        cfg_s <= ~cfg_v;
        wait_run(PC_RESET);
        rd_chk(ADDR_RESET_CTRL, 8'h1B);
        done("stack_cfg");
    endtask

    task automatic t_brownout();
        @(posedge ref_clk);
        bo_low <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk_bit(cpu_rst, 1'b1);
        bo_low <= 1'b0;
        wait_run(PC_RESET);
        chk_bit(n >= 32, 1'b1);
        rd_chk(ADDR_RESET_CTRL, 8'h3E);
        reg_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wr_reg(ADDR_RESET_CTRL, 8'h33);
        bo_low <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk_bit(cpu_rst, 1'b0);
        rd_chk(ADDR_RESET_CTRL, 8'h3E);
        done("brownout");
    endtask

    initial
    begin
        fail_count = 0;
        check_count = 0;
        sys_rst <= 1'b1; hold <= 1'b1; bo_low <= 1'b0; reg_en <= 1'b1;
        cfg_v <= {CFG_COUNT{8'hA5}}; cfg_s <= {CFG_COUNT{8'h5A}};
        mode <= MODE_FULL; pc <= 21'h000000; ev <= '0;
        addr <= 4'h0; wd <= 8'h00; wr <= 1'b0; rd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_power_on();
        t_soft_wdt();
        t_wake();
        t_stack_cfg();
        t_brownout();
        give_verdict();
    end
endmodule
